/* srtc_pkg.sv */
// Package with register map, field positions, reset values and divider counts
package srtc_pkg;

  // ----------------------------------------
  // Register addresses
  // ----------------------------------------
  localparam logic [7:0] SRTC_ADDR_CTRL = 8'h91;
  localparam logic [7:0] SRTC_ADDR_RLD_LO = 8'h92;
  localparam logic [7:0] SRTC_ADDR_RLD_HI = 8'h93;
  localparam logic [7:0] SRTC_ADDR_CNT_LO = 8'h94;
  localparam logic [7:0] SRTC_ADDR_CNT_HI = 8'h95;

  // ----------------------------------------
  // timer_control field positions
  // ----------------------------------------
  localparam int SRTC_BIT_TFH = 7;
  localparam int SRTC_BIT_TFL = 6;
  localparam int SRTC_BIT_LEN = 5;
  localparam int SRTC_BIT_CAP = 4;
  localparam int SRTC_BIT_SPLIT = 3;
  localparam int SRTC_BIT_RUN = 2;
  localparam int SRTC_BIT_ZERO = 1;
  localparam int SRTC_BIT_XCLK = 0;

  // ----------------------------------------
  // Reset values and divider counts
  // ----------------------------------------
  localparam logic [7:0] SRTC_CTRL_RST = 8'h00;
  localparam logic [7:0] SRTC_BYTE_RST = 8'h00;
  localparam logic [7:0] SRTC_BYTE_MAX = 8'hff;
  localparam logic [7:0] SRTC_CTRL_WMASK = 8'hfd;
  localparam int SRTC_SYS_DIV = 12;
  localparam int SRTC_EXT_DIV = 8;

  // Count enables produced by the prescaler
  typedef struct packed {
    logic sys;
    logic div12;
    logic ext8;
    logic ext_fall;
  } srtc_tick_s;

endpackage

/* srtc_prescale.sv */
// Prescaler: system clock divide-by-12 enable and synchronised external divide-by-8
`timescale 1ns/1ps
module srtc_prescale
  import srtc_pkg::*;
#(
  parameter int SYS_DIV = SRTC_SYS_DIV,
  parameter int EXT_DIV = SRTC_EXT_DIV
)
(
  input wire logic ref_clk, // System clock
  input wire logic sys_rst, // Async reset, active high
  input wire logic ext_osc, // External oscillator pin
  output srtc_tick_s ticks // One-cycle count enables
);

  localparam int EW = $clog2(EXT_DIV);
  localparam logic [3:0] SYS_LAST = 4'(SYS_DIV - 1);

  logic [3:0] div12_r;
  logic [2:0] sync_r;
  logic ext_lvl_r;
  logic [EW-1:0] ext_cnt_r;
  logic ext_rise;
  logic div12_wrap;
  logic ext_wrap;

  // ----------------------------------------
  // System clock divider
  // ----------------------------------------
  assign div12_wrap = (div12_r == SYS_LAST); // [RULE2]
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      div12_r <= 4'h0;
    else
      div12_r <= div12_wrap ? 4'h0 : div12_r + 4'h1;
  end

  // ----------------------------------------
  // External oscillator synchroniser
  // ----------------------------------------
  // A change counts only once stages two and three agree; stage one feeds stage two alone
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sync_r <= 3'h0;
      ext_lvl_r <= 1'b0;
    end
    else
    begin
      sync_r <= {sync_r[1:0], ext_osc}; // [RULE2]
      if (sync_r[1] == sync_r[2])
        ext_lvl_r <= sync_r[2];
    end
  end
  assign ext_rise = sync_r[1] & sync_r[2] & ~ext_lvl_r;

  // Divide-by-8 of the synchronised oscillator; its falling edge is the wrap
  assign ext_wrap = ext_rise & (ext_cnt_r == EW'(EXT_DIV - 1));
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      ext_cnt_r <= '0;
    else if (ext_rise)
      ext_cnt_r <= ext_cnt_r + EW'(1);
  end

  // Enables
  assign ticks.sys = 1'b1;
  assign ticks.div12 = div12_wrap;
  assign ticks.ext8 = ext_wrap; // [RULE2]
  assign ticks.ext_fall = ext_wrap; // [RULE13]

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  div12_space_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ticks.div12 |=> !ticks.div12 [*8]) // [RULE2]
    else $error("divide-by-12 enable came too early");
  ext_fall_space_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ticks.ext_fall |=> !ticks.ext_fall [*8]) // [RULE13]
    else $error("capture event faster than oscillator divided by 8");

endmodule

/* srtc_timer.sv */
// Split auto-reload timer with external oscillator capture
// Behaviour
// [RULE1] Two 8-bit bytes form one 16-bit reload counter, or two 8-bit ones when split.
// [RULE2] Count clock is system clock, system clock /12, or synchronised external /8.
// [RULE3] Wide mode: rollover from all ones loads reload value and sets high flag.
// [RULE4] Wide mode: interrupt request on every 16-bit overflow when timer interrupt enabled.
// [RULE5] Wide mode: low-byte rollover also interrupts when low interrupt enable is set.
// [RULE6] Split mode: each byte reloads from its own reload byte on its own overflow.
// [RULE7] Split mode: run bit gates only the high byte; low byte always counts.
// [RULE8] Per-half select: 1 system clock; 0 defers to external select (/12 or ext/8).
// [RULE9] Split mode: high flag on high byte wrap, low flag on low byte wrap.
// [RULE10] Split mode: interrupt on high overflow, or either when low enable set.
// [RULE11] Overflow flags are only cleared by software writes, never by hardware.
// [RULE12] Capture event copies the 16-bit count into reload bytes and sets high flag.
// [RULE13] Capture event is each falling edge of synchronised external oscillator /8.
// [RULE14] Capture mode count clock is system clock or /12 from low select and external select.
// [RULE15] Software should capture only in wide mode with a much faster count clock.
// [RULE16] High flag is control bit 7, read/write, reset to 0.
// [RULE17] Wide mode advances only while run bit set, once per selected tick.
// [RULE18] Control bit 1 always reads 0 and ignores writes.
`timescale 1ns/1ps
module srtc_timer
  import srtc_pkg::*;
(
  input wire logic REF_CLK, // System clock, 100 MHz
  input wire logic SYS_RST, // Async reset, active high
  input wire logic EXT_OSC, // External oscillator pin
  input wire logic [7:0] REG_ADDR, // Register address
  input wire logic [7:0] REG_WDATA, // Write data
  input wire logic REG_WE, // Write strobe, one cycle
  output logic [7:0] REG_RDATA, // Read data, one cycle after address
  input wire logic HIGH_HALF_CLOCK_SELECT, // 1: high byte on system clock in split mode
  input wire logic LOW_HALF_CLOCK_SELECT, // 1: low byte on system clock
  input wire logic TIMER_IRQ_ENABLE, // Timer interrupt enable
  output logic TIMER_IRQ // Interrupt request level
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [7:0] ctrl_r;
  logic [7:0] ctrl_nxt;
  logic [7:0] cnt_lo_r;
  logic [7:0] cnt_lo_nxt;
  logic [7:0] cnt_hi_r;
  logic [7:0] cnt_hi_nxt;
  logic [7:0] rld_lo_r;
  logic [7:0] rld_lo_nxt;
  logic [7:0] rld_hi_r;
  logic [7:0] rld_hi_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic irq_r;
  srtc_tick_s ticks;

  srtc_prescale srtc_prescale_inst (
    .ref_clk(REF_CLK),
    .sys_rst(SYS_RST),
    .ext_osc(EXT_OSC),
    .ticks(ticks)
  );

  // ----------------------------------------
  // Control fields and decode
  // ----------------------------------------
  wire split_mode_select = ctrl_r[SRTC_BIT_SPLIT];
  wire run_control = ctrl_r[SRTC_BIT_RUN];
  wire capture_mode_enable = ctrl_r[SRTC_BIT_CAP];
  wire low_overflow_irq_enable = ctrl_r[SRTC_BIT_LEN];
  wire external_clock_select = ctrl_r[SRTC_BIT_XCLK];
  wire high_overflow_flag = ctrl_r[SRTC_BIT_TFH];
  wire low_overflow_flag = ctrl_r[SRTC_BIT_TFL];
  wire wr_ctrl = REG_WE & (REG_ADDR == SRTC_ADDR_CTRL);
  wire wr_rld_lo = REG_WE & (REG_ADDR == SRTC_ADDR_RLD_LO);
  wire wr_rld_hi = REG_WE & (REG_ADDR == SRTC_ADDR_RLD_HI);
  wire wr_cnt_lo = REG_WE & (REG_ADDR == SRTC_ADDR_CNT_LO);
  wire wr_cnt_hi = REG_WE & (REG_ADDR == SRTC_ADDR_CNT_HI);

  // ----------------------------------------
  // Clock source selection
  // ----------------------------------------
  // In capture mode the oscillator is the thing measured, so it never clocks the low byte or the wide count
  wire ext_or_div = external_clock_select ? ticks.ext8 : ticks.div12; // [RULE8]
  wire cap_src = external_clock_select ? ticks.sys : ticks.div12; // [RULE14]
  wire tick_lo = LOW_HALF_CLOCK_SELECT ? ticks.sys
               : (capture_mode_enable ? cap_src : ext_or_div); // [RULE8] [RULE14]
  wire tick_hi = HIGH_HALF_CLOCK_SELECT ? ticks.sys : ext_or_div; // [RULE8]

  // ----------------------------------------
  // Count enables and overflow events
  // ----------------------------------------
  wire lo_max = (cnt_lo_r == SRTC_BYTE_MAX);
  wire hi_max = (cnt_hi_r == SRTC_BYTE_MAX);
  wire wide_inc = ~split_mode_select & run_control & tick_lo; // [RULE17]
  wire lo_inc = split_mode_select ? tick_lo : wide_inc; // [RULE7]
  wire hi_inc = split_mode_select ? (run_control & tick_hi) : (wide_inc & lo_max); // [RULE7]
  wire lo_ovf = lo_inc & lo_max; // [RULE9]
  wire hi_ovf = hi_inc & hi_max; // [RULE3] [RULE9]
  wire wide_ovf = wide_inc & lo_max & hi_max; // [RULE3]
  wire capture_evt = capture_mode_enable & ticks.ext_fall; // [RULE12] [RULE13]

  // ----------------------------------------
  // Counter next values
  // ----------------------------------------
  // A software byte write wins over counting in the same cycle
  always_comb
  begin
    cnt_lo_nxt = cnt_lo_r;
    cnt_hi_nxt = cnt_hi_r;
    if (split_mode_select)
    begin
      if (lo_inc)
        cnt_lo_nxt = lo_max ? rld_lo_r : cnt_lo_r + 8'h01; // [RULE6]
      if (hi_inc)
        cnt_hi_nxt = hi_max ? rld_hi_r : cnt_hi_r + 8'h01; // [RULE6]
    end
    else if (wide_inc)
    begin
      if (wide_ovf)
      begin
        cnt_lo_nxt = rld_lo_r; // [RULE3]
        cnt_hi_nxt = rld_hi_r; // [RULE3]
      end
      else
      begin
        cnt_lo_nxt = cnt_lo_r + 8'h01; // [RULE1]
        if (lo_max)
          cnt_hi_nxt = cnt_hi_r + 8'h01; // [RULE1]
      end
    end
    if (wr_cnt_lo)
      cnt_lo_nxt = REG_WDATA;
    if (wr_cnt_hi)
      cnt_hi_nxt = REG_WDATA;
  end

  // ----------------------------------------
  // Reload next values
  // ----------------------------------------
  // Capture wins over a reload write: losing a timestamp is worse than a late write
  assign rld_lo_nxt = capture_evt ? cnt_lo_r : (wr_rld_lo ? REG_WDATA : rld_lo_r); // [RULE12]
  assign rld_hi_nxt = capture_evt ? cnt_hi_r : (wr_rld_hi ? REG_WDATA : rld_hi_r); // [RULE12]

  // ----------------------------------------
  // Control next value
  // ----------------------------------------
  // Hardware set beats a software clear arriving in the same cycle
  always_comb
  begin
    ctrl_nxt = ctrl_r;
    if (wr_ctrl)
      ctrl_nxt = REG_WDATA & SRTC_CTRL_WMASK; // [RULE16] [RULE18]
    if (hi_ovf | capture_evt)
      ctrl_nxt[SRTC_BIT_TFH] = 1'b1; // [RULE3] [RULE9] [RULE11] [RULE12]
    if (lo_ovf)
      ctrl_nxt[SRTC_BIT_TFL] = 1'b1; // [RULE9] [RULE11]
  end

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  always_comb
  begin
    case (REG_ADDR)
      SRTC_ADDR_CTRL: rdata_nxt = ctrl_r;
      SRTC_ADDR_RLD_LO: rdata_nxt = rld_lo_r;
      SRTC_ADDR_RLD_HI: rdata_nxt = rld_hi_r;
      SRTC_ADDR_CNT_LO: rdata_nxt = cnt_lo_r;
      SRTC_ADDR_CNT_HI: rdata_nxt = cnt_hi_r;
      default: rdata_nxt = 8'h00;
    endcase
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      ctrl_r <= SRTC_CTRL_RST;
      cnt_lo_r <= SRTC_BYTE_RST;
      cnt_hi_r <= SRTC_BYTE_RST;
      rld_lo_r <= SRTC_BYTE_RST;
      rld_hi_r <= SRTC_BYTE_RST;
      rdata_r <= 8'h00;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      cnt_lo_r <= cnt_lo_nxt;
      cnt_hi_r <= cnt_hi_nxt;
      rld_lo_r <= rld_lo_nxt;
      rld_hi_r <= rld_hi_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Interrupt request follows the sticky flags one cycle later
  always_ff @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      irq_r <= 1'b0;
    else
      irq_r <= TIMER_IRQ_ENABLE
             & (high_overflow_flag | (low_overflow_irq_enable & low_overflow_flag)); // [RULE4] [RULE5] [RULE10]
  end

  assign REG_RDATA = rdata_r;
  assign TIMER_IRQ = irq_r;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);

  wire no_cnt_wr = ~wr_cnt_lo & ~wr_cnt_hi;

  wide_reload_a: assert property ( // [RULE3]
    wide_inc & lo_max & hi_max & no_cnt_wr
    |=> {cnt_hi_r, cnt_lo_r} == {$past(rld_hi_r), $past(rld_lo_r)} && high_overflow_flag)
    else $error("wide overflow did not reload and flag");
  wide_step_a: assert property ( // [RULE1]
    wide_inc & ~(lo_max & hi_max) & no_cnt_wr
    |=> {cnt_hi_r, cnt_lo_r} == $past({cnt_hi_r, cnt_lo_r}) + 16'h0001)
    else $error("wide counter did not step by one");
  wide_gated_a: assert property ( // [RULE17]
    ~split_mode_select & ~run_control & no_cnt_wr
    |=> $stable({cnt_hi_r, cnt_lo_r}))
    else $error("stopped wide counter moved");
  split_lo_free_a: assert property ( // [RULE7]
    split_mode_select & ~run_control & tick_lo & ~lo_max & ~wr_cnt_lo
    |=> cnt_lo_r == $past(cnt_lo_r) + 8'h01)
    else $error("split low byte not free running");
  split_lo_reload_a: assert property ( // [RULE6]
    split_mode_select & tick_lo & lo_max & ~wr_cnt_lo
    |=> cnt_lo_r == $past(rld_lo_r) && low_overflow_flag)
    else $error("split low byte did not reload");
  flag_sticky_a: assert property ( // [RULE11]
    high_overflow_flag & ~wr_ctrl |=> high_overflow_flag)
    else $error("high flag cleared without a write");
  capture_copy_a: assert property ( // [RULE12]
    capture_evt |=> rld_lo_r == $past(cnt_lo_r) && rld_hi_r == $past(cnt_hi_r)
                    && high_overflow_flag)
    else $error("capture did not copy count");
  irq_follow_a: assert property ( // [RULE10]
    TIMER_IRQ_ENABLE & low_overflow_irq_enable & low_overflow_flag |=> TIMER_IRQ)
    else $error("low overflow did not interrupt");
  zero_bit_a: assert property ( // [RULE18]
    REG_ADDR == SRTC_ADDR_CTRL |=> !REG_RDATA[SRTC_BIT_ZERO])
    else $error("control bit 1 read as one");
  tfh_write_a: assert property ( // [RULE16]
    wr_ctrl & REG_WDATA[SRTC_BIT_TFH] |=> high_overflow_flag)
    else $error("high flag not writable");

  // Split high byte: reload, run gating and its own clock select
  split_hi_reload_a: assert property ( // [RULE6] [RULE9]
    split_mode_select & hi_inc & hi_max & ~wr_cnt_hi
    |=> cnt_hi_r == $past(rld_hi_r) && high_overflow_flag)
    else $error("split high byte did not reload");
  split_hi_gated_a: assert property ( // [RULE7]
    split_mode_select & ~run_control & ~wr_cnt_hi
    |=> $stable(cnt_hi_r))
    else $error("stopped split high byte moved");
  split_hi_step_a: assert property ( // [RULE8]
    split_mode_select & run_control & HIGH_HALF_CLOCK_SELECT & ~hi_max & ~wr_cnt_hi
    |=> cnt_hi_r == $past(cnt_hi_r) + 8'h01)
    else $error("high byte missed a system clock count");

  // Wide low wrap, low flag stickiness and the control write path
  wide_low_flag_a: assert property ( // [RULE5]
    ~split_mode_select & wide_inc & lo_max
    |=> low_overflow_flag)
    else $error("wide low wrap did not set low flag");
  low_flag_sticky_a: assert property ( // [RULE11]
    low_overflow_flag & ~wr_ctrl
    |=> low_overflow_flag)
    else $error("low flag cleared without a write");
  ctrl_write_a: assert property ( // [RULE16] [RULE18]
    wr_ctrl & ~hi_ovf & ~lo_ovf & ~capture_evt
    |=> ctrl_r == ($past(REG_WDATA) & SRTC_CTRL_WMASK))
    else $error("control write did not land");

  // Request line against the flags and the enable
  high_irq_a: assert property ( // [RULE4]
    TIMER_IRQ_ENABLE & high_overflow_flag
    |=> TIMER_IRQ)
    else $error("high overflow did not interrupt");
  irq_masked_a: assert property ( // [RULE10]
    ~TIMER_IRQ_ENABLE
    |=> ~TIMER_IRQ)
    else $error("request raised while disabled");

  // With external select set, the wide capture count runs on the system clock, never on the oscillator
  capture_clock_a: assert property ( // [RULE14]
    capture_mode_enable & ~LOW_HALF_CLOCK_SELECT & external_clock_select & run_control
    & ~split_mode_select & ~lo_max & no_cnt_wr
    |=> cnt_lo_r == $past(cnt_lo_r) + 8'h01)
    else $error("capture count clock not system clock");

  wide_ovf_c: cover property (wide_ovf);
  split_hi_ovf_c: cover property (split_mode_select & hi_ovf);
  capture_c: cover property (capture_evt ##[1:200] capture_evt);
  set_beats_clear_c: cover property (wr_ctrl & ~REG_WDATA[SRTC_BIT_TFL] & lo_ovf);
  split_lo_irq_c: cover property (split_mode_select & lo_ovf & low_overflow_irq_enable);

endmodule

/* srtc_timer_tb.sv */
// Self-checking testbench for the split auto-reload timer
`timescale 1ns/1ps
module srtc_timer_tb
  import srtc_pkg::*;
;
  // ----------------------------------------
  // Stimulus signals and bookkeeping
  // ----------------------------------------
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic ext_osc = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_we = 1'b0;
  logic hi_sel = 1'b0;
  logic lo_sel = 1'b0;
  logic irq_en = 1'b0;
  logic [7:0] reg_rdata;
  logic timer_irq;
  logic [31:0] rng = 32'hc91e;
  logic [1:0] ext_cnt = 2'h0;
  int miscompares = 0;
  int n_compared = 0;

  srtc_timer srtc_timer_inst (
    .REF_CLK(ref_clk),
    .SYS_RST(sys_rst),
    .EXT_OSC(ext_osc),
    .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata),
    .REG_WE(reg_we),
    .REG_RDATA(reg_rdata),
    .HIGH_HALF_CLOCK_SELECT(hi_sel),
    .LOW_HALF_CLOCK_SELECT(lo_sel),
    .TIMER_IRQ_ENABLE(irq_en),
    .TIMER_IRQ(timer_irq)
  );

  // System clock, 100 MHz
  always #5 ref_clk = ~ref_clk;

  // External oscillator: period of 8 system cycles, so ext/8 ticks every 64 cycles
  always @(posedge ref_clk)
  begin
    ext_cnt <= ext_cnt + 2'h1;
    if (ext_cnt == 2'h3)
      ext_osc <= ~ext_osc;
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  // Write takes effect at the edge where the strobe is seen high
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge ref_clk);
    reg_we <= 1'b0;
  endtask

  // Read data is registered: valid one edge after the address is driven
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    @(posedge ref_clk);
    #1 d = reg_rdata;
  endtask

  task automatic cfg(input logic hs, input logic ls, input logic ie);
    @(posedge ref_clk);
    hi_sel <= hs;
    lo_sel <= ls;
    irq_en <= ie;
  endtask

  // Expected control read-back: bit 1 never reads as one
  function automatic logic [7:0] ctrl_view(input logic [7:0] w);
    return w & ~(8'h01 << SRTC_BIT_ZERO);
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Range check, used where prescaler phase or sequence timing leaves a count uncertain
  task automatic chk_in(input logic [7:0] got, input logic [7:0] lo, input logic [7:0] hi);
    n_compared++;
    if ($isunknown(got) || got < lo || got > hi)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h to %h", $time, got, lo, hi);
    end
  endtask

  // Request line is a level, so sample it away from the edge
  task automatic chk_irq(input logic e);
    @(posedge ref_clk);
    #1 chk({7'h00, timer_irq}, {7'h00, e});
  endtask

  task automatic give_verdict;
    $display("Compared %0d, mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Watchdog sized well above the fewer than two thousand cycles the sequence needs
  initial
  begin
    #(10 * 60000);
    miscompares++;
    give_verdict();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    logic [7:0] d;
    logic [7:0] e;
    logic [15:0] cap0;
    logic [15:0] cap1;
    int i;
    repeat (20) @(posedge ref_clk);
    sys_rst <= 1'b0;
    // Reset values, last address is unmapped
    for (i = 0; i < 6; i++)
    begin
      rd(SRTC_ADDR_CTRL + 8'(i), d);
      chk(d, 8'h00);
    end
    wr(SRTC_ADDR_CTRL, 8'h02);
    rd(SRTC_ADDR_CTRL, d);
    chk(d, ctrl_view(8'h02));
    // Software may set the high flag; request follows the enable
    wr(SRTC_ADDR_CTRL, 8'h80);
    rd(SRTC_ADDR_CTRL, d);
    chk(d, ctrl_view(8'h80));
    chk_irq(1'b0);
    cfg(1'b0, 1'b0, 1'b1);
    chk_irq(1'b1);
    wr(SRTC_ADDR_CTRL, 8'h00);
    chk_irq(1'b0);
    // Random byte read-back while stopped
    for (i = 0; i < 8; i++)
    begin
      rng = xs(rng);
      e = rng[7:0];
      wr(SRTC_ADDR_RLD_LO + 8'(i % 4), e);
      rd(SRTC_ADDR_RLD_LO + 8'(i % 4), d);
      chk(d, e);
    end
    // Wide overflow reloads 16 bits and sets the flags
    rng = xs(rng);
    e = rng[15:8] & 8'h7f;
    cfg(1'b0, 1'b1, 1'b1);
    wr(SRTC_ADDR_RLD_LO, 8'h10);
    wr(SRTC_ADDR_RLD_HI, e);
    wr(SRTC_ADDR_CNT_LO, 8'hf0);
    wr(SRTC_ADDR_CNT_HI, 8'hff);
    wr(SRTC_ADDR_CTRL, 8'h04);
    repeat (30) @(posedge ref_clk);
    rd(SRTC_ADDR_CTRL, d);
    chk(d, 8'hc4);
    chk_irq(1'b1);
    wr(SRTC_ADDR_CTRL, 8'hc0);
    rd(SRTC_ADDR_CNT_HI, d);
    chk(d, e);
    rd(SRTC_ADDR_CNT_LO, d);
    chk_in(d, 8'h10, 8'h40);
    repeat (50) @(posedge ref_clk);
    rd(SRTC_ADDR_CNT_LO, e);
    chk(e, d);
    rd(SRTC_ADDR_CTRL, d);
    chk(d, 8'hc0);
    // Low-byte wrap only: request needs the low enable
    wr(SRTC_ADDR_CNT_LO, 8'hf8);
    wr(SRTC_ADDR_CNT_HI, 8'h00);
    wr(SRTC_ADDR_CTRL, 8'h04);
    repeat (20) @(posedge ref_clk);
    rd(SRTC_ADDR_CTRL, d);
    chk(d, 8'h44);
    chk_irq(1'b0);
    wr(SRTC_ADDR_CTRL, 8'h60);
    chk_irq(1'b1);
    // Split mode: low byte runs with run bit clear
    wr(SRTC_ADDR_CTRL, 8'h00);
    cfg(1'b1, 1'b1, 1'b1);
    wr(SRTC_ADDR_RLD_LO, 8'hf0);
    wr(SRTC_ADDR_RLD_HI, 8'ha0);
    wr(SRTC_ADDR_CNT_LO, 8'hfc);
    wr(SRTC_ADDR_CNT_HI, 8'hff);
    wr(SRTC_ADDR_CTRL, 8'h08);
    repeat (20) @(posedge ref_clk);
    rd(SRTC_ADDR_CTRL, d);
    chk(d, 8'h48);
    chk_irq(1'b0);
    rd(SRTC_ADDR_CNT_HI, d);
    chk(d, 8'hff);
    rd(SRTC_ADDR_CNT_LO, d);
    chk_in(d, 8'hf0, 8'hff);
    wr(SRTC_ADDR_CTRL, 8'h0c);
    repeat (10) @(posedge ref_clk);
    rd(SRTC_ADDR_CTRL, d);
    chk(d & 8'hbf, 8'h8c);
    chk_irq(1'b1);
    rd(SRTC_ADDR_CNT_HI, d);
    chk_in(d, 8'ha0, 8'hc0);
    // Split with low enable: a low wrap alone interrupts; high byte on divide-by-12
    cfg(1'b0, 1'b1, 1'b1);
    wr(SRTC_ADDR_CTRL, 8'h28);
    wr(SRTC_ADDR_CNT_HI, 8'h00);
    repeat (20) @(posedge ref_clk);
    rd(SRTC_ADDR_CTRL, d);
    chk(d, 8'h68);
    chk_irq(1'b1);
    wr(SRTC_ADDR_CTRL, 8'h2c);
    repeat (120) @(posedge ref_clk);
    wr(SRTC_ADDR_CTRL, 8'h28);
    rd(SRTC_ADDR_CNT_HI, d);
    chk_in(d, 8'h09, 8'h0b);
    // Divide-by-12 then external divide-by-8 counting
    wr(SRTC_ADDR_CTRL, 8'h00);
    cfg(1'b0, 1'b0, 1'b0);
    wr(SRTC_ADDR_CNT_LO, 8'h00);
    wr(SRTC_ADDR_CNT_HI, 8'h00);
    wr(SRTC_ADDR_CTRL, 8'h04);
    repeat (120) @(posedge ref_clk);
    wr(SRTC_ADDR_CTRL, 8'h00);
    rd(SRTC_ADDR_CNT_LO, d);
    chk_in(d, 8'h09, 8'h0b);
    wr(SRTC_ADDR_CNT_LO, 8'h00);
    wr(SRTC_ADDR_CTRL, 8'h05);
    repeat (640) @(posedge ref_clk);
    wr(SRTC_ADDR_CTRL, 8'h01);
    rd(SRTC_ADDR_CNT_LO, d);
    chk_in(d, 8'h09, 8'h0b);
    // Capture in wide mode, external select on: count runs on the system clock
    cfg(1'b0, 1'b0, 1'b0);
    wr(SRTC_ADDR_CNT_LO, 8'h00);
    wr(SRTC_ADDR_CNT_HI, 8'h00);
    wr(SRTC_ADDR_CTRL, 8'h15);
    for (int k = 0; k < 2; k++)
    begin
      d = 8'h00;
      for (i = 0; i < 100 && d[7] !== 1'b1; i++)
        rd(SRTC_ADDR_CTRL, d);
      chk({7'h00, d[7]}, 8'h01);
      rd(SRTC_ADDR_RLD_LO, e);
      rd(SRTC_ADDR_RLD_HI, d);
      cap0 = cap1;
      cap1 = {d, e};
      wr(SRTC_ADDR_CTRL, 8'h15);
    end
    cap1 = cap1 - cap0;
    chk(cap1[7:0], 8'h40);
    chk(cap1[15:8], 8'h00);
    give_verdict();
  end
endmodule
